// ---- rtl/dawd_pkg.sv ----
/*
 * constants for the digital acoustic wake detector: register indices, field
 * positions, reset values, interrupt bits and timing counts.
 * assumes a 250 MHz system clock; registers sit at byte address 4 * index.
 */
package dawd_pkg;
	// ************************************************************
	// register indices (byte address is four times the index)
	// ************************************************************
	localparam logic [6:0] IDX_DETECT_ENABLE     = 7'h29;
	localparam logic [6:0] IDX_FLOOR_HIGH        = 7'h2a;
	localparam logic [6:0] IDX_FLOOR_LOW         = 7'h2b;
	localparam logic [6:0] IDX_RESERVED_A        = 7'h2c;
	localparam logic [6:0] IDX_RESERVED_B        = 7'h2d;
	localparam logic [6:0] IDX_REL_PULSE_LOW     = 7'h2e;
	localparam logic [6:0] IDX_PULSE_MIN_HIGH    = 7'h2f;
	localparam logic [6:0] IDX_ABS_PULSE_LOW     = 7'h30;
	localparam logic [6:0] IDX_ABS_THR_LOW       = 7'h31;
	localparam logic [6:0] IDX_ABS_THR_HIGH      = 7'h32;
	localparam logic [6:0] IDX_REL_THR_GAIN      = 7'h33;
	localparam logic [6:0] IDX_UNUSED_C          = 7'h35;
	localparam logic [6:0] IDX_UNUSED_D          = 7'h36;
	localparam logic [6:0] IDX_IRQ_STATUS        = 7'h40;
	localparam logic [6:0] IDX_IRQ_MASK          = 7'h41;
	localparam logic [6:0] IDX_STATE             = 7'h42;
	// unlock key addresses, in the order they must be written
	localparam logic [6:0] IDX_KEY0              = 7'h5c;
	localparam logic [6:0] IDX_KEY1              = 7'h3e;
	localparam logic [6:0] IDX_KEY2              = 7'h6f;
	localparam logic [6:0] IDX_KEY3              = 7'h3b;
	localparam logic [6:0] IDX_KEY4              = 7'h4c;
	localparam logic [7:0] KEY_DATA              = 8'h00;
	localparam logic [2:0] KEY_STEPS             = 3'h5;

	// ************************************************************
	// fields and reset values
	// ************************************************************
	localparam int         BIT_VARIANT_ONE       = 0;
	localparam int         BIT_VARIANT_TWO       = 1;
	localparam int         BIT_ANALOG_EN         = 4;
	localparam logic [7:0] MASK_DETECT_ENABLE    = 8'h13;
	localparam logic [7:0] MASK_HIGH5            = 8'h1f;
	localparam logic [7:0] RESET_BYTE            = 8'h00;
	// interrupt status bits
	localparam int         IRQ_WAKE_RISE         = 0;
	localparam int         IRQ_WAKE_FALL         = 1;
	localparam int         IRQ_UNLOCKED          = 2;
	localparam int         IRQ_REFUSED           = 3;
	localparam int         IRQ_BITS              = 4;
	// state register bits
	localparam int         ST_UNLOCKED           = 0;
	localparam int         ST_CLOCK_PRESENT      = 1;
	localparam int         ST_ACTIVE             = 2;
	localparam int         ST_WAKE               = 3;
	localparam logic [1:0] RESP_OKAY             = 2'b00;
	localparam logic [1:0] RESP_SLVERR           = 2'b10;

	// ************************************************************
	// timing
	// ************************************************************
	localparam longint     SYS_CLK_KHZ           = 250000;
	localparam longint     REL_BASE_NS           = 700000;
	localparam longint     ABS_BASE_NS           = 1100000;
	localparam longint     PULSE_STEP_NS         = 93400;
	localparam longint     ACT_PERIOD_NS         = 1302;
	localparam longint     ACT_TOL_NS            = 65;
	localparam longint     CLK_LOST_NS           = 20000;
	localparam int         REL_BASE_CYC  = int'(REL_BASE_NS * SYS_CLK_KHZ / 1000000);
	localparam int         ABS_BASE_CYC  = int'(ABS_BASE_NS * SYS_CLK_KHZ / 1000000);
	localparam int         STEP_CYC      = int'(PULSE_STEP_NS * SYS_CLK_KHZ / 1000000);
	localparam int         ACT_MIN_CYC   = int'(((ACT_PERIOD_NS - ACT_TOL_NS) * SYS_CLK_KHZ
	                                            + 999999) / 1000000);
	localparam int         ACT_MAX_CYC   = int'((ACT_PERIOD_NS + ACT_TOL_NS) * SYS_CLK_KHZ
	                                            / 1000000);
	localparam int         CLK_LOST_CYC  = int'(CLK_LOST_NS * SYS_CLK_KHZ / 1000000);
endpackage

// ---- rtl/dawd_top.sv ----
/*
 * digital acoustic wake detector control: axi4-lite register slave, unlock
 * key sequence, mode detection from the external clock, minimum pulse timers
 * for the absolute and relative comparators, wake output and interrupt.
 * assumes the analog comparators and the device clock arrive asynchronously;
 * all of them pass three synchroniser flip-flops and one filter flip-flop before use.
 */
`timescale 1ns/100ps
`default_nettype none

module dawd_top #(
	parameter int ADDR_W       = 10,
	parameter int REL_BASE_CYC = dawd_pkg::REL_BASE_CYC,
	parameter int ABS_BASE_CYC = dawd_pkg::ABS_BASE_CYC,
	parameter int STEP_CYC     = dawd_pkg::STEP_CYC,
	parameter int ACT_MIN_CYC  = dawd_pkg::ACT_MIN_CYC,
	parameter int ACT_MAX_CYC  = dawd_pkg::ACT_MAX_CYC,
	parameter int CLK_LOST_CYC = dawd_pkg::CLK_LOST_CYC
) (
	// clock and reset
	input  wire logic                 clk_sys_i,
	input  wire logic                 rst_i,
	// axi4-lite write
	input  wire logic [ADDR_W-1:0]    s_axi_awaddr_i,
	input  wire logic                 s_axi_awvalid_i,
	output logic                      s_axi_awready_o,
	input  wire logic [31:0]          s_axi_wdata_i,
	input  wire logic [3:0]           s_axi_wstrb_i,
	input  wire logic                 s_axi_wvalid_i,
	output logic                      s_axi_wready_o,
	output logic [1:0]                s_axi_bresp_o,
	output logic                      s_axi_bvalid_o,
	input  wire logic                 s_axi_bready_i,
	// axi4-lite read
	input  wire logic [ADDR_W-1:0]    s_axi_araddr_i,
	input  wire logic                 s_axi_arvalid_i,
	output logic                      s_axi_arready_o,
	output logic [31:0]               s_axi_rdata_o,
	output logic [1:0]                s_axi_rresp_o,
	output logic                      s_axi_rvalid_o,
	input  wire logic                 s_axi_rready_i,
	// device clock pin and analog comparator results
	input  wire logic                 dev_clk_i,
	input  wire logic                 abs_above_i,
	input  wire logic                 rel_above_i,
	// settings toward the analog front end
	output logic [12:0]               absolute_level_setting_o,
	output logic [12:0]               floor_level_o,
	output logic [7:0]                relative_level_offset_o,
	output logic                      analog_detector_enable_o,
	output logic                      detect_active_o,
	// wake pin and interrupt
	output logic                      wake_o,
	output logic                      irq_o
);
	if (ADDR_W < 9 || ADDR_W > 32) begin : g_bad_addr_w
		$error("dawd_top: ADDR_W must be 9..32");
	end
	if (STEP_CYC < 1 || ACT_MIN_CYC < 2 || ACT_MAX_CYC < ACT_MIN_CYC) begin : g_bad_timing
		$error("dawd_top: timing parameters out of range");
	end
	if (CLK_LOST_CYC <= ACT_MAX_CYC) begin : g_bad_lost
		$error("dawd_top: CLK_LOST_CYC too small");
	end

	// ************************************************************
	// input synchronisers
	// ************************************************************
	// index 0 device clock, 1 absolute comparator, 2 relative comparator
	logic [2:0] async_in;
	logic [2:0] sync1_reg, sync2_reg, sync3_reg;
	logic [2:0] filt_reg;
	assign async_in = {rel_above_i, abs_above_i, dev_clk_i};

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			sync1_reg <= 3'h0;
			sync2_reg <= 3'h0;
			sync3_reg <= 3'h0;
		end else begin
			sync1_reg <= async_in;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	// a level counts only once two stages agree, which rejects one-cycle glitches
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_filt
			always_ff @(posedge clk_sys_i or posedge rst_i) begin
				if (rst_i)
					filt_reg[gi] <= 1'b0;
				else if (sync2_reg[gi] == sync3_reg[gi])
					filt_reg[gi] <= sync3_reg[gi];
			end
		end
	endgenerate

	// ************************************************************
	// clock rate measurement
	// ************************************************************
	logic        clk_prev_reg;
	logic        clk_rise;
	logic [31:0] period_cnt_reg;
	logic        clk_present_reg;
	logic        active_reg;
	assign clk_rise = filt_reg[0] & ~clk_prev_reg;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			clk_prev_reg <= 1'b0;
		else
			clk_prev_reg <= filt_reg[0];
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			period_cnt_reg <= 32'h0;
		else if (clk_rise)
			period_cnt_reg <= 32'h1;
		else if (period_cnt_reg < 32'(CLK_LOST_CYC))
			period_cnt_reg <= period_cnt_reg + 32'h1;
	end

	// mode is judged one whole period at a time; a stopped clock drops it
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			clk_present_reg <= 1'b0;
			active_reg      <= 1'b0;
		end else if (period_cnt_reg >= 32'(CLK_LOST_CYC)) begin
			clk_present_reg <= 1'b0;
			active_reg      <= 1'b0;
		end else if (clk_rise) begin
			clk_present_reg <= 1'b1;
			active_reg      <= (period_cnt_reg >= 32'(ACT_MIN_CYC)) &&
			                   (period_cnt_reg <= 32'(ACT_MAX_CYC));
		end
	end

	// ************************************************************
	// axi4-lite write channel
	// ************************************************************
	logic        aw_held_reg, w_held_reg, bvalid_reg;
	logic [6:0]  wr_idx_reg;
	logic [7:0]  wr_byte_reg;
	logic        wr_lane_reg;
	logic        wr_hi_zero_reg;
	logic [1:0]  bresp_reg;
	logic        do_write;
	logic        wr_mapped;
	logic        wr_setting;
	logic        wr_key;

	assign s_axi_awready_o = ~aw_held_reg & ~bvalid_reg;
	assign s_axi_wready_o  = ~w_held_reg & ~bvalid_reg;
	assign s_axi_bvalid_o  = bvalid_reg;
	assign s_axi_bresp_o   = bresp_reg;
	assign do_write        = aw_held_reg & w_held_reg & ~bvalid_reg;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			aw_held_reg <= 1'b0;
			wr_idx_reg  <= 7'h0;
		end else if (s_axi_awvalid_i && s_axi_awready_o) begin
			aw_held_reg <= 1'b1;
			wr_idx_reg  <= s_axi_awaddr_i[8:2];
		end else if (do_write) begin
			aw_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			w_held_reg     <= 1'b0;
			wr_byte_reg    <= 8'h00;
			wr_lane_reg    <= 1'b0;
			wr_hi_zero_reg <= 1'b0;
		end else if (s_axi_wvalid_i && s_axi_wready_o) begin
			w_held_reg     <= 1'b1;
			wr_byte_reg    <= s_axi_wdata_i[7:0];
			wr_lane_reg    <= s_axi_wstrb_i[0];
			wr_hi_zero_reg <= (s_axi_wdata_i[31:8] == 24'h0);
		end else if (do_write) begin
			w_held_reg <= 1'b0;
		end
	end

	// only the low byte lane carries register data
	always_comb begin
		wr_setting = 1'b0;
		wr_key     = 1'b0;
		wr_mapped  = 1'b1;
		case (wr_idx_reg)
			dawd_pkg::IDX_DETECT_ENABLE, dawd_pkg::IDX_FLOOR_HIGH, dawd_pkg::IDX_FLOOR_LOW,
			dawd_pkg::IDX_RESERVED_A, dawd_pkg::IDX_RESERVED_B, dawd_pkg::IDX_REL_PULSE_LOW,
			dawd_pkg::IDX_PULSE_MIN_HIGH, dawd_pkg::IDX_ABS_PULSE_LOW,
			dawd_pkg::IDX_ABS_THR_LOW, dawd_pkg::IDX_ABS_THR_HIGH,
			dawd_pkg::IDX_REL_THR_GAIN, dawd_pkg::IDX_UNUSED_C,
			dawd_pkg::IDX_UNUSED_D:  wr_setting = 1'b1;
			dawd_pkg::IDX_KEY0, dawd_pkg::IDX_KEY1, dawd_pkg::IDX_KEY2,
			dawd_pkg::IDX_KEY3, dawd_pkg::IDX_KEY4: wr_key = 1'b1;
			dawd_pkg::IDX_IRQ_STATUS, dawd_pkg::IDX_IRQ_MASK,
			dawd_pkg::IDX_STATE: ;
			default:                 wr_mapped = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= dawd_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= wr_mapped ? dawd_pkg::RESP_OKAY : dawd_pkg::RESP_SLVERR;
		end else if (s_axi_bready_i) begin
			bvalid_reg <= 1'b0;
		end
	end

	// ************************************************************
	// unlock key sequence
	// ************************************************************
	logic [2:0] key_step_reg;
	logic [6:0] key_expect;
	logic       unlocked;
	logic       key_ok;
	assign unlocked = (key_step_reg == dawd_pkg::KEY_STEPS);
	assign key_ok   = wr_lane_reg && wr_hi_zero_reg && (wr_byte_reg == dawd_pkg::KEY_DATA);

	always_comb begin
		case (key_step_reg)
			3'h0:    key_expect = dawd_pkg::IDX_KEY0;
			3'h1:    key_expect = dawd_pkg::IDX_KEY1;
			3'h2:    key_expect = dawd_pkg::IDX_KEY2;
			3'h3:    key_expect = dawd_pkg::IDX_KEY3;
			default: key_expect = dawd_pkg::IDX_KEY4;
		endcase
	end

	// a key write out of order restarts the sequence; once open it stays open
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			key_step_reg <= 3'h0;
		else if (do_write && wr_key && !unlocked) begin
			if (key_ok && wr_idx_reg == key_expect)
				key_step_reg <= key_step_reg + 3'h1;
			else if (key_ok && wr_idx_reg == dawd_pkg::IDX_KEY0)
				key_step_reg <= 3'h1;
			else
				key_step_reg <= 3'h0;
		end
	end

	// ************************************************************
	// detector settings
	// ************************************************************
	logic [7:0] enable_reg, floor_hi_reg, floor_lo_reg, rel_lo_reg, pulse_hi_reg;
	logic [7:0] abs_lo_reg, thr_lo_reg, thr_hi_reg, gain_reg;
	logic       set_wr;
	assign set_wr = do_write && wr_lane_reg && wr_setting && unlocked;

	// reserved bits are dropped on write and read back as zero
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			enable_reg   <= dawd_pkg::RESET_BYTE;
			floor_hi_reg <= dawd_pkg::RESET_BYTE;
			floor_lo_reg <= dawd_pkg::RESET_BYTE;
			rel_lo_reg   <= dawd_pkg::RESET_BYTE;
			pulse_hi_reg <= dawd_pkg::RESET_BYTE;
			abs_lo_reg   <= dawd_pkg::RESET_BYTE;
			thr_lo_reg   <= dawd_pkg::RESET_BYTE;
			thr_hi_reg   <= dawd_pkg::RESET_BYTE;
			gain_reg     <= dawd_pkg::RESET_BYTE;
		end else if (set_wr) begin
			case (wr_idx_reg)
				dawd_pkg::IDX_DETECT_ENABLE:  enable_reg   <= wr_byte_reg &
				                                               dawd_pkg::MASK_DETECT_ENABLE;
				dawd_pkg::IDX_FLOOR_HIGH:     floor_hi_reg <= wr_byte_reg & dawd_pkg::MASK_HIGH5;
				dawd_pkg::IDX_FLOOR_LOW:      floor_lo_reg <= wr_byte_reg;
				dawd_pkg::IDX_REL_PULSE_LOW:  rel_lo_reg   <= wr_byte_reg;
				dawd_pkg::IDX_PULSE_MIN_HIGH: pulse_hi_reg <= wr_byte_reg;
				dawd_pkg::IDX_ABS_PULSE_LOW:  abs_lo_reg   <= wr_byte_reg;
				dawd_pkg::IDX_ABS_THR_LOW:    thr_lo_reg   <= wr_byte_reg;
				dawd_pkg::IDX_ABS_THR_HIGH:   thr_hi_reg   <= wr_byte_reg & dawd_pkg::MASK_HIGH5;
				dawd_pkg::IDX_REL_THR_GAIN:   gain_reg     <= wr_byte_reg;
				default: ;
			endcase
		end
	end

	logic [11:0] rel_min, abs_min;
	logic        digital_en;
	assign rel_min    = {pulse_hi_reg[3:0], rel_lo_reg};
	assign abs_min    = {pulse_hi_reg[7:4], abs_lo_reg};
	assign digital_en = enable_reg[dawd_pkg::BIT_VARIANT_ONE] |
	                    enable_reg[dawd_pkg::BIT_VARIANT_TWO];

	assign absolute_level_setting_o = {thr_hi_reg[4:0], thr_lo_reg};
	assign floor_level_o            = {floor_hi_reg[4:0], floor_lo_reg};
	assign relative_level_offset_o  = gain_reg;
	assign analog_detector_enable_o = enable_reg[dawd_pkg::BIT_ANALOG_EN];
	assign detect_active_o          = active_reg & digital_en;

	// ************************************************************
	// minimum pulse timers, one per threshold path
	// ************************************************************
	// path 0 absolute, path 1 relative; the timer restarts whenever a path drops
	logic [31:0] target [2];
	logic [31:0] dur_cnt_reg [2];
	logic [1:0]  hit;
	assign target[0] = 32'(ABS_BASE_CYC) + 32'(abs_min) * 32'(STEP_CYC);
	assign target[1] = 32'(REL_BASE_CYC) + 32'(rel_min) * 32'(STEP_CYC);

	generate
		for (gi = 0; gi < 2; gi++) begin : g_path
			logic above;
			assign above   = filt_reg[gi + 1] & detect_active_o;
			assign hit[gi] = above && (dur_cnt_reg[gi] >= target[gi]);

			always_ff @(posedge clk_sys_i or posedge rst_i) begin
				if (rst_i)
					dur_cnt_reg[gi] <= 32'h0;
				else if (!above)
					dur_cnt_reg[gi] <= 32'h0;
				else if (dur_cnt_reg[gi] < target[gi])
					dur_cnt_reg[gi] <= dur_cnt_reg[gi] + 32'h1;
			end
		end
	endgenerate

	// ************************************************************
	// wake output and interrupt
	// ************************************************************
	logic                wake_reg;
	logic                unlocked_prev_reg;
	localparam int IRQ_BITS_W = dawd_pkg::IRQ_BITS - 1;
	logic [IRQ_BITS_W:0] irq_unused;
	logic [IRQ_BITS_W:0] irq_event, irq_status_reg, irq_mask_reg, irq_clear;
	assign wake_o = wake_reg;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			wake_reg <= 1'b0;
		else
			wake_reg <= |hit;
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			unlocked_prev_reg <= 1'b0;
		else
			unlocked_prev_reg <= unlocked;
	end

	always_comb begin
		irq_event = '0;
		irq_event[dawd_pkg::IRQ_WAKE_RISE] = (|hit) & ~wake_reg;
		irq_event[dawd_pkg::IRQ_WAKE_FALL] = ~(|hit) & wake_reg;
		irq_event[dawd_pkg::IRQ_UNLOCKED]  = unlocked & ~unlocked_prev_reg;
		irq_event[dawd_pkg::IRQ_REFUSED]   = do_write & wr_setting & ~unlocked;
	end
	assign irq_unused = '0;
	assign irq_clear  = (do_write && wr_lane_reg && wr_idx_reg == dawd_pkg::IDX_IRQ_STATUS) ?
	                    wr_byte_reg[IRQ_BITS_W:0] : irq_unused;

	// a new event in the clearing cycle wins over the clear
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			irq_status_reg <= '0;
		else
			irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_event;
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			irq_mask_reg <= '0;
		else if (do_write && wr_lane_reg && wr_idx_reg == dawd_pkg::IDX_IRQ_MASK)
			irq_mask_reg <= wr_byte_reg[IRQ_BITS_W:0];
	end

	assign irq_o = |(irq_status_reg & irq_mask_reg);

	// ************************************************************
	// axi4-lite read channel
	// ************************************************************
	logic        rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0]  rresp_reg;
	logic [7:0]  rd_byte;
	logic        rd_mapped;
	assign s_axi_arready_o = ~rvalid_reg;
	assign s_axi_rvalid_o  = rvalid_reg;
	assign s_axi_rdata_o   = rdata_reg;
	assign s_axi_rresp_o   = rresp_reg;

	// key registers are write-only and read as zero
	always_comb begin
		rd_byte   = 8'h00;
		rd_mapped = 1'b1;
		case (s_axi_araddr_i[8:2])
			dawd_pkg::IDX_DETECT_ENABLE:  rd_byte = enable_reg;
			dawd_pkg::IDX_FLOOR_HIGH:     rd_byte = floor_hi_reg;
			dawd_pkg::IDX_FLOOR_LOW:      rd_byte = floor_lo_reg;
			dawd_pkg::IDX_REL_PULSE_LOW:  rd_byte = rel_lo_reg;
			dawd_pkg::IDX_PULSE_MIN_HIGH: rd_byte = pulse_hi_reg;
			dawd_pkg::IDX_ABS_PULSE_LOW:  rd_byte = abs_lo_reg;
			dawd_pkg::IDX_ABS_THR_LOW:    rd_byte = thr_lo_reg;
			dawd_pkg::IDX_ABS_THR_HIGH:   rd_byte = thr_hi_reg;
			dawd_pkg::IDX_REL_THR_GAIN:   rd_byte = gain_reg;
			dawd_pkg::IDX_IRQ_STATUS:     rd_byte = 8'(irq_status_reg);
			dawd_pkg::IDX_IRQ_MASK:       rd_byte = 8'(irq_mask_reg);
			dawd_pkg::IDX_STATE:          rd_byte = {4'h0, wake_reg, active_reg,
			                                         clk_present_reg, unlocked};
			dawd_pkg::IDX_RESERVED_A, dawd_pkg::IDX_RESERVED_B,
			dawd_pkg::IDX_UNUSED_C, dawd_pkg::IDX_UNUSED_D,
			dawd_pkg::IDX_KEY0, dawd_pkg::IDX_KEY1, dawd_pkg::IDX_KEY2,
			dawd_pkg::IDX_KEY3, dawd_pkg::IDX_KEY4: rd_byte = 8'h00;
			default:                      rd_mapped = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0;
			rresp_reg  <= dawd_pkg::RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= {24'h0, rd_byte};
			rresp_reg  <= rd_mapped ? dawd_pkg::RESP_OKAY : dawd_pkg::RESP_SLVERR;
		end else if (s_axi_rready_i) begin
			rvalid_reg <= 1'b0;
		end
	end

endmodule // dawd_top

`default_nettype wire

// ---- bench/dawd_checker.sv ----
/*
 * port-level assertions for dawd_top: axi handshakes, wake timing.
 * assumes the bind below and the design's parameter REL_BASE_CYC.
 */
`timescale 1ns/100ps
`default_nettype none
module dawd_checker #(
	parameter int REL_BASE_CYC = 20
) (
	// clock, reset and bus handshakes
	input wire logic clk_sys_i, rst_i, s_axi_bvalid_o, s_axi_bready_i,
	input wire logic s_axi_rvalid_o, s_axi_rready_i, s_axi_awready_o,
	// comparators and wake
	input wire logic abs_above_i, rel_above_i, detect_active_o, wake_o
);
	// ************
	// properties
	// ************
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	// raw comparator run length; raw input leads the filtered one, so it bounds wake
	logic [15:0] run_len;
	always_ff @(posedge clk_sys_i or posedge rst_i)
		if (rst_i) run_len <= '0;
		else if (!(abs_above_i || rel_above_i)) run_len <= '0;
		else if (run_len != 16'hffff) run_len <= run_len + 16'h1;
	sequence s_quiet; !abs_above_i && !rel_above_i; endsequence
	a_bresp_holds: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
		else $error("bvalid dropped before bready");
	a_rdata_holds: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o)
		else $error("rvalid dropped before rready");
	a_aw_blocked: assert property (s_axi_bvalid_o |-> !s_axi_awready_o)
		else $error("awready high during response");
	a_min_pulse: assert property ($rose(wake_o) |-> run_len >= 16'(REL_BASE_CYC))
		else $error("wake rose before minimum duration");
	a_wake_cause: assert property ($rose(wake_o) |-> $past(abs_above_i || rel_above_i))
		else $error("wake rose without a comparator");
	a_wake_active: assert property (wake_o |-> detect_active_o || $past(detect_active_o))
		else $error("wake high while detection inactive");
	a_wake_falls: assert property (s_quiet [*8] |=> !wake_o)
		else $error("wake stayed high after stimulus ended");
	a_wake_holds: assert property ($fell(wake_o) && $past(detect_active_o) |->
		$past(!abs_above_i && !rel_above_i, 2))
		else $error("wake fell while stimulus held");
endmodule // dawd_checker
bind dawd_top dawd_checker #(.REL_BASE_CYC(REL_BASE_CYC)) u_chk (.clk_sys_i, .rst_i,
	.s_axi_bvalid_o, .s_axi_bready_i, .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_awready_o,
	.abs_above_i, .rel_above_i, .detect_active_o, .wake_o);
`default_nettype wire

// ---- bench/dawd_host_clk.sv ----
/*
 * host clock source for the device clock pin.
 * assumes the bench picks the rate: slow (2.5 MHz) or the active-rate stand-in.
 */
`timescale 1ns/100ps
`default_nettype none
module dawd_host_clk (
	input  wire logic fast_i,
	output var logic  dev_clk_o
);
	// clock runs from power-up; its first rising edge comes at 200 ns, after the first register writes
	initial dev_clk_o = 1'b0;
	always begin
		#(fast_i ? 80 : 200);
		dev_clk_o = ~dev_clk_o;
	end
endmodule // dawd_host_clk
`default_nettype wire

// ---- bench/dawd_tb_top.sv ----
/*
 * self-checking bench for dawd_top: registers, unlock, interrupt, pulse timing.
 * assumes dawd_host_clk and the bound dawd_checker are compiled with it.
 */
`timescale 1ns/100ps
`default_nettype none
module dawd_tb_top;
	logic clk_sys_i = 0, rst_i = 1, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
	logic s_axi_arvalid_i = 0, s_axi_rready_i = 0, abs_above_i = 0, rel_above_i = 0, fast = 0;
	logic [9:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
	logic [31:0] s_axi_wdata_i = '0, s_axi_rdata_o;
	logic [3:0] s_axi_wstrb_i = 4'h1;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
	logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	logic dev_clk_i, analog_detector_enable_o, detect_active_o, wake_o, irq_o;
	logic [12:0] absolute_level_setting_o, floor_level_o;
	logic [7:0] relative_level_offset_o;
	logic [6:0] keys [5] = '{7'h5c, 7'h3e, 7'h6f, 7'h3b, 7'h4c};
	int fail_count = 0, num_checks = 0;
	always #2 clk_sys_i = ~clk_sys_i;
	dawd_host_clk u_host (.fast_i(fast), .dev_clk_o(dev_clk_i));
	dawd_top #(.REL_BASE_CYC(20), .ABS_BASE_CYC(30), .STEP_CYC(2), .ACT_MIN_CYC(38),
		.ACT_MAX_CYC(42)) u_dut (.clk_sys_i, .rst_i, .s_axi_awaddr_i,
		.s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
		.s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
		.s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
		.s_axi_rready_i, .dev_clk_i, .abs_above_i, .rel_above_i, .absolute_level_setting_o,
		.floor_level_o, .relative_level_offset_o, .analog_detector_enable_o,
		.detect_active_o, .wake_o, .irq_o);
	task automatic chk(input string what, input logic [31:0] exp, got);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [6:0] idx, input logic [7:0] d, input logic [1:0] er = 2'b00,
		input logic [3:0] st = 4'h1);
		logic ad, wd;
		ad = 0;
		wd = 0;
		@(posedge clk_sys_i);
		s_axi_awaddr_i <= {1'b0, idx, 2'b00};
		s_axi_wdata_i <= {24'h0, d};
		s_axi_wstrb_i <= st;
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'b111;
		do begin
			@(negedge clk_sys_i);
			ad |= s_axi_awready_o;
			wd |= s_axi_wready_o;
			@(posedge clk_sys_i);
			if (ad) s_axi_awvalid_i <= 1'b0;
			if (wd) s_axi_wvalid_i <= 1'b0;
		end while (!(ad && wd));
		do @(negedge clk_sys_i); while (!s_axi_bvalid_o);
		chk("bresp", er, s_axi_bresp_o);
		@(posedge clk_sys_i);
		s_axi_bready_i <= 1'b0;
	endtask
	task automatic rd(input logic [6:0] idx, input logic [7:0] ed, input logic [1:0] er = 2'b00);
		@(posedge clk_sys_i);
		s_axi_araddr_i <= {1'b0, idx, 2'b00};
		{s_axi_arvalid_i, s_axi_rready_i} <= 2'b11;
		do @(negedge clk_sys_i); while (!s_axi_arready_o);
		@(posedge clk_sys_i);
		s_axi_arvalid_i <= 1'b0;
		do @(negedge clk_sys_i); while (!s_axi_rvalid_o);
		chk("rdata", {24'h0, ed}, s_axi_rdata_o);
		chk("rresp", er, s_axi_rresp_o);
		@(posedge clk_sys_i);
		s_axi_rready_i <= 1'b0;
	endtask
	task automatic pulse(input bit rel, input int n, input logic ew);
		@(posedge clk_sys_i);
		if (rel) rel_above_i <= 1'b1; else abs_above_i <= 1'b1;
		repeat (n) @(posedge clk_sys_i);
		{rel_above_i, abs_above_i} <= 2'b00;
		#1 chk("wake", ew, wake_o);
		repeat (12) @(posedge clk_sys_i);
		#1 chk("wake low", 1'b0, wake_o);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		fail_count++;
		complete_run;
	end
	initial begin
		repeat (6) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		wr(7'h2e, 8'h5a);
		rd(7'h2e, 8'h00);
		rd(7'h40, 8'h08);
		#1 chk("irq masked", 1'b0, irq_o);
		wr(7'h41, 8'h08);
		#1 chk("irq", 1'b1, irq_o);
		wr(7'h40, 8'h08);
		#1 chk("irq clear", 1'b0, irq_o);
		wr(7'h10, 8'h01, 2'b10);
		rd(7'h10, 8'h00, 2'b10);
		$display("test locked done");
		wr(keys[0], 8'h00);
		wr(keys[1], 8'h00);
		wr(keys[3], 8'h00);
		rd(7'h40, 8'h00);
		foreach (keys[i]) wr(keys[i], 8'h00);
		rd(7'h40, 8'h04);
		wr(7'h2f, 8'h5a);
		rd(7'h2f, 8'h5a);
		wr(7'h2f, 8'h00, 2'b00, 4'h0);
		rd(7'h2f, 8'h5a);
		wr(7'h2e, 8'h03);
		wr(7'h2f, 8'h00);
		wr(7'h30, 8'h05);
		wr(7'h31, 8'h13);
		wr(7'h32, 8'h01);
		chk("abs level", 13'h0113, absolute_level_setting_o);
		wr(7'h2a, 8'h1f);
		wr(7'h2b, 8'h24);
		wr(7'h33, 8'h24);
		chk("rel offset", 8'h24, relative_level_offset_o);
		chk("floor", 13'h1f24, floor_level_o);
		wr(7'h29, 8'h13);
		rd(7'h29, 8'h13);
		chk("analog enable", 1'b1, analog_detector_enable_o);
		wr(7'h29, 8'h01);
		$display("test config done");
		pulse(0, 60, 1'b0);
		fast <= 1'b1;
		repeat (200) @(posedge clk_sys_i);
		chk("active", 1'b1, detect_active_o);
		pulse(0, 30, 1'b0);
		pulse(0, 60, 1'b1);
		pulse(1, 20, 1'b0);
		pulse(1, 40, 1'b1);
		wr(7'h29, 8'h02);
		pulse(0, 60, 1'b1);
		wr(7'h29, 8'h00);
		pulse(0, 60, 1'b0);
		wr(7'h29, 8'h01);
		fast <= 1'b0;
		repeat (300) @(posedge clk_sys_i);
		chk("inactive", 1'b0, detect_active_o);
		$display("test detect done");
		complete_run;
	end
endmodule // dawd_tb_top
`default_nettype wire
